/* core/mag_i2c_pkg.sv */
// register map, reset values and bus constants of the magnetic two-wire slave.
// assumes a 20 MHz system clock that oversamples the serial clock and data.
package mag_i2c_pkg;

	localparam int CLK_PERIOD_NS = 50;
	localparam int FAST_BIT_NS = 2500;
	// system clocks per fast-rate bit; the oversampler needs several per scl phase
	localparam int FAST_BIT_CYCLES = FAST_BIT_NS / CLK_PERIOD_NS;

	localparam logic [6:0] SLAVE_ADDR_FIELD = 7'h1E;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	localparam logic [7:0] OFS_CONFIG_A = 8'h00;
	localparam logic [7:0] OFS_CONFIG_B = 8'h01;
	localparam logic [7:0] OFS_OPERATING_MODE = 8'h02;
	localparam logic [7:0] OFS_FIELD_X_MSB = 8'h03;
	localparam logic [7:0] OFS_FIELD_X_LSB = 8'h04;
	localparam logic [7:0] OFS_FIELD_Y_MSB = 8'h05;
	localparam logic [7:0] OFS_FIELD_Y_LSB = 8'h06;
	localparam logic [7:0] OFS_FIELD_Z_MSB = 8'h07;
	localparam logic [7:0] OFS_FIELD_Z_LSB = 8'h08;
	localparam logic [7:0] OFS_SENSOR_STATE = 8'h09;
	localparam logic [7:0] OFS_IDENT_FIRST = 8'h0A;
	localparam logic [7:0] OFS_IDENT_SECOND = 8'h0B;
	localparam logic [7:0] OFS_IDENT_THIRD = 8'h0C;
	localparam logic [7:0] OFS_PTR_ZERO = 8'h00;

	localparam logic [7:0] RST_CONFIG_A = 8'h10;
	localparam logic [7:0] RST_CONFIG_B = 8'h20;
	localparam logic [7:0] RST_OPERATING_MODE = 8'h03;

	// bit positions software may change; the rest stay untouched
	localparam logic [7:0] MASK_CONFIG_A = 8'hFF;
	localparam logic [7:0] MASK_CONFIG_B = 8'hFF;
	localparam logic [7:0] MASK_OPERATING_MODE = 8'hFF;

	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} field_sample_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_PTR,
		ST_ACK_PTR,
		ST_WDATA,
		ST_ACK_WDATA,
		ST_RDATA,
		ST_RACK
	} link_state_e;

endpackage

/* core/mag_i2c_slave.sv */
// two-wire slave port of the magnetic sensor with its register file.
// assumes scl_in/sda_in are asynchronous pins; sample and sensor_state_in come from this clock domain.
// Notes on behaviour
// - works at 100 or 400 kbit/s; clk oversamples both lines.
// - each byte is eight bits then one acknowledge bit.
// - signed field values leave as two's complement bytes.
// - answer only address 0011110; write byte 3C, read byte 3D.
// - addressed receiver pulls data low on ninth clock to acknowledge.
// - data changes only while clock is low, except bus conditions.
// - start is data falling with clock high; stop is data rising.
// - repeated start without stop begins a fresh address phase.
// - address byte: seven address bits, then read one or write zero.
// - data bytes follow the address acknowledge; stop ends each transaction.
// - pointer selects location; loaded from first byte after write address.
// - pointer advances by one after each access, no master action.
// - pointer at status location goes back to the first field location.
// - access at or above the last ident location wraps pointer to zero.
// - the pointer value itself has no read path.
// - reading an undefined location returns zero.
// - writes to undefined locations or bits change nothing.
// - calibration and configuration values come back at power-up.
`timescale 1ns/100ps
module mag_i2c_slave #(
	parameter logic [7:0] IDENT_FIRST_VAL = 8'hA5,  // arbitrary value
	parameter logic [7:0] IDENT_SECOND_VAL = 8'h5A, // arbitrary value
	parameter logic [7:0] IDENT_THIRD_VAL = 8'hC3   // arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire mag_i2c_pkg::field_sample_s sample,
	input wire logic [7:0] sensor_state_in,
	output logic [7:0] config_a,
	output logic [7:0] config_b,
	output logic [7:0] operating_mode
);

	logic [2:0] scl_pipe_reg;
	logic [2:0] sda_pipe_reg;
	mag_i2c_pkg::link_state_e state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic read_reg;
	logic master_ack_reg;
	logic sda_oe_reg;
	logic sda_out_reg;
	logic [7:0] config_a_reg;
	logic [7:0] config_b_reg;
	logic [7:0] operating_mode_reg;
	mag_i2c_pkg::field_sample_s snap_reg;

	// only stage 1 feeds stage 2; edge logic looks at stages 2 and 3
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_pipe_reg <= 3'h7;
			sda_pipe_reg <= 3'h7;
		end
		else
		begin
			scl_pipe_reg <= {scl_pipe_reg[1:0], scl_in};
			sda_pipe_reg <= {sda_pipe_reg[1:0], sda_in};
		end
	end

	wire scl_now = scl_pipe_reg[1];
	wire scl_old = scl_pipe_reg[2];
	wire sda_now = sda_pipe_reg[1];
	wire sda_old = sda_pipe_reg[2];
	wire scl_rise = scl_now & ~scl_old;
	wire scl_fall = ~scl_now & scl_old;
	wire start_det = scl_now & scl_old & sda_old & ~sda_now;
	wire stop_det = scl_now & scl_old & ~sda_old & sda_now;
	wire byte_done = (bit_cnt_reg == mag_i2c_pkg::BITS_PER_BYTE);
	wire addr_match = (shift_reg[7:1] == mag_i2c_pkg::SLAVE_ADDR_FIELD);

	// next pointer: status wraps to first field, top ident wraps to zero
	wire [7:0] ptr_next = (ptr_reg == mag_i2c_pkg::OFS_SENSOR_STATE) ? mag_i2c_pkg::OFS_FIELD_X_MSB
		: (ptr_reg >= mag_i2c_pkg::OFS_IDENT_THIRD) ? mag_i2c_pkg::OFS_PTR_ZERO
		: ptr_reg + 8'h01;

	// low byte of each axis is read from a snapshot taken with X high
	wire [7:0] rd_data =
		(ptr_reg == mag_i2c_pkg::OFS_CONFIG_A) ? config_a_reg :
		(ptr_reg == mag_i2c_pkg::OFS_CONFIG_B) ? config_b_reg :
		(ptr_reg == mag_i2c_pkg::OFS_OPERATING_MODE) ? operating_mode_reg :
		(ptr_reg == mag_i2c_pkg::OFS_FIELD_X_MSB) ? sample.x[15:8] :
		(ptr_reg == mag_i2c_pkg::OFS_FIELD_X_LSB) ? snap_reg.x[7:0] :
		(ptr_reg == mag_i2c_pkg::OFS_FIELD_Y_MSB) ? snap_reg.y[15:8] :
		(ptr_reg == mag_i2c_pkg::OFS_FIELD_Y_LSB) ? snap_reg.y[7:0] :
		(ptr_reg == mag_i2c_pkg::OFS_FIELD_Z_MSB) ? snap_reg.z[15:8] :
		(ptr_reg == mag_i2c_pkg::OFS_FIELD_Z_LSB) ? snap_reg.z[7:0] :
		(ptr_reg == mag_i2c_pkg::OFS_SENSOR_STATE) ? sensor_state_in :
		(ptr_reg == mag_i2c_pkg::OFS_IDENT_FIRST) ? IDENT_FIRST_VAL :
		(ptr_reg == mag_i2c_pkg::OFS_IDENT_SECOND) ? IDENT_SECOND_VAL :
		(ptr_reg == mag_i2c_pkg::OFS_IDENT_THIRD) ? IDENT_THIRD_VAL :
		8'h00;

	wire in_rx = (state_reg == mag_i2c_pkg::ST_ADDR) || (state_reg == mag_i2c_pkg::ST_PTR)
		|| (state_reg == mag_i2c_pkg::ST_WDATA);
	wire ack_state = (state_reg == mag_i2c_pkg::ST_ACK_ADDR) || (state_reg == mag_i2c_pkg::ST_ACK_PTR)
		|| (state_reg == mag_i2c_pkg::ST_ACK_WDATA);
	wire ptr_load = scl_fall && (state_reg == mag_i2c_pkg::ST_PTR) && byte_done;
	wire wr_strobe = scl_fall && (state_reg == mag_i2c_pkg::ST_WDATA) && byte_done;
	wire rd_sent = scl_fall && (state_reg == mag_i2c_pkg::ST_RDATA) && byte_done;
	wire ptr_adv = wr_strobe || rd_sent;
	// the outgoing byte is frozen at the ack fall so a sample update cannot tear a byte mid-shift
	wire tx_load = scl_fall && (((state_reg == mag_i2c_pkg::ST_ACK_ADDR) && read_reg)
		|| ((state_reg == mag_i2c_pkg::ST_RACK) && master_ack_reg));
	wire addr_nack = scl_fall && (state_reg == mag_i2c_pkg::ST_ADDR) && byte_done && !addr_match;
	wire wr_a = wr_strobe && (ptr_reg == mag_i2c_pkg::OFS_CONFIG_A);
	wire wr_b = wr_strobe && (ptr_reg == mag_i2c_pkg::OFS_CONFIG_B);
	wire wr_m = wr_strobe && (ptr_reg == mag_i2c_pkg::OFS_OPERATING_MODE);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= mag_i2c_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			read_reg <= 1'b0;
			master_ack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end
		else if (start_det)
		begin
			state_reg <= mag_i2c_pkg::ST_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_oe_reg <= 1'b0;
		end
		else if (stop_det)
		begin
			state_reg <= mag_i2c_pkg::ST_IDLE;
			sda_oe_reg <= 1'b0;
		end
		else if (scl_rise)
		begin
			if (in_rx && !byte_done)
			begin
				shift_reg <= {shift_reg[6:0], sda_now};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			if (state_reg == mag_i2c_pkg::ST_RDATA && !byte_done)
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			if (state_reg == mag_i2c_pkg::ST_RACK)
				master_ack_reg <= !sda_now;
		end
		else if (scl_fall)
		begin
			unique case (state_reg)
				mag_i2c_pkg::ST_IDLE:
					sda_oe_reg <= 1'b0;
				mag_i2c_pkg::ST_ADDR, mag_i2c_pkg::ST_PTR, mag_i2c_pkg::ST_WDATA:
					if (byte_done)
					begin
						if (addr_nack)
							state_reg <= mag_i2c_pkg::ST_IDLE;
						else
						begin
							sda_oe_reg <= 1'b1;
							if (state_reg == mag_i2c_pkg::ST_ADDR)
							begin
								read_reg <= shift_reg[0];
								state_reg <= mag_i2c_pkg::ST_ACK_ADDR;
							end
							else if (state_reg == mag_i2c_pkg::ST_PTR)
								state_reg <= mag_i2c_pkg::ST_ACK_PTR;
							else
								state_reg <= mag_i2c_pkg::ST_ACK_WDATA;
						end
					end
				mag_i2c_pkg::ST_ACK_ADDR, mag_i2c_pkg::ST_ACK_PTR, mag_i2c_pkg::ST_ACK_WDATA:
				begin
					bit_cnt_reg <= 4'h0;
					if (tx_load)
					begin
						state_reg <= mag_i2c_pkg::ST_RDATA;
						sda_oe_reg <= !rd_data[7];
					end
					else
					begin
						sda_oe_reg <= 1'b0;
						state_reg <= (state_reg == mag_i2c_pkg::ST_ACK_ADDR) ? mag_i2c_pkg::ST_PTR
							: mag_i2c_pkg::ST_WDATA;
					end
				end
				mag_i2c_pkg::ST_RDATA:
					if (byte_done)
					begin
						sda_oe_reg <= 1'b0; // release for the master's acknowledge
						state_reg <= mag_i2c_pkg::ST_RACK;
					end
					else
						sda_oe_reg <= !tx_reg[3'h7 - bit_cnt_reg[2:0]];
				mag_i2c_pkg::ST_RACK:
				begin
					bit_cnt_reg <= 4'h0;
					sda_oe_reg <= master_ack_reg && !rd_data[7];
					state_reg <= master_ack_reg ? mag_i2c_pkg::ST_RDATA : mag_i2c_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// pointer, outgoing byte and snapshot; the pointer never reaches rd_data
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ptr_reg <= mag_i2c_pkg::OFS_PTR_ZERO;
			tx_reg <= 8'h00;
			snap_reg <= '0;
		end
		else
		begin
			if (ptr_load)
				ptr_reg <= shift_reg;
			else if (ptr_adv)
				ptr_reg <= ptr_next;
			if (tx_load)
				tx_reg <= rd_data;
			if (tx_load && ptr_reg == mag_i2c_pkg::OFS_FIELD_X_MSB)
				snap_reg <= sample;
		end
	end

	// reset restores the boot values; masked bits are never written
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			config_a_reg <= mag_i2c_pkg::RST_CONFIG_A;
			config_b_reg <= mag_i2c_pkg::RST_CONFIG_B;
			operating_mode_reg <= mag_i2c_pkg::RST_OPERATING_MODE;
		end
		else
		begin
			if (wr_a)
				config_a_reg <= (config_a_reg & ~mag_i2c_pkg::MASK_CONFIG_A)
					| (shift_reg & mag_i2c_pkg::MASK_CONFIG_A);
			if (wr_b)
				config_b_reg <= (config_b_reg & ~mag_i2c_pkg::MASK_CONFIG_B)
					| (shift_reg & mag_i2c_pkg::MASK_CONFIG_B);
			if (wr_m)
				operating_mode_reg <= (operating_mode_reg & ~mag_i2c_pkg::MASK_OPERATING_MODE)
					| (shift_reg & mag_i2c_pkg::MASK_OPERATING_MODE);
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sda_out_reg <= 1'b0;
		else
			sda_out_reg <= 1'b0;
	end

	assign sda_out = sda_out_reg;
	assign sda_oe = sda_oe_reg;
	assign config_a = config_a_reg;
	assign config_b = config_b_reg;
	assign operating_mode = operating_mode_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_addr_ack;
		scl_fall && state_reg == mag_i2c_pkg::ST_ADDR && byte_done && addr_match && !start_det && !stop_det
			|=> sda_oe_reg && state_reg == mag_i2c_pkg::ST_ACK_ADDR;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address match not acknowledged");

	property p_addr_nack;
		addr_nack && !start_det && !stop_det |=> !sda_oe_reg && state_reg == mag_i2c_pkg::ST_IDLE;
	endproperty
	a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");

	property p_restart;
		start_det |=> state_reg == mag_i2c_pkg::ST_ADDR && bit_cnt_reg == 4'h0 && !sda_oe_reg;
	endproperty
	a_restart: assert property (p_restart) else $error("start did not open address phase");

	property p_stop;
		stop_det && !start_det |=> state_reg == mag_i2c_pkg::ST_IDLE && !sda_oe_reg;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not release the bus");

	property p_wrap_status;
		ptr_adv && !ptr_load && ptr_reg == mag_i2c_pkg::OFS_SENSOR_STATE |=> ptr_reg == mag_i2c_pkg::OFS_FIELD_X_MSB;
	endproperty
	a_wrap_status: assert property (p_wrap_status) else $error("status pointer did not wrap");

	property p_wrap_top;
		ptr_adv && !ptr_load && ptr_reg >= mag_i2c_pkg::OFS_IDENT_THIRD |=> ptr_reg == mag_i2c_pkg::OFS_PTR_ZERO;
	endproperty
	a_wrap_top: assert property (p_wrap_top) else $error("high pointer did not wrap to zero");

	property p_inc;
		ptr_adv && ptr_reg < mag_i2c_pkg::OFS_SENSOR_STATE |=> ptr_reg == $past(ptr_reg) + 8'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("pointer did not advance by one");

	property p_ptr_load;
		ptr_load |=> ptr_reg == $past(shift_reg);
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded from first byte");

	property p_zero_read;
		tx_load && ptr_reg > mag_i2c_pkg::OFS_IDENT_THIRD |=> tx_reg == 8'h00;
	endproperty
	a_zero_read: assert property (p_zero_read) else $error("undefined location read nonzero");

	property p_ro_write;
		wr_strobe && ptr_reg > mag_i2c_pkg::OFS_OPERATING_MODE
			|=> $stable(config_a_reg) && $stable(config_b_reg) && $stable(operating_mode_reg);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("write to read-only location changed state");

	property p_sda_low_clock;
		$changed(sda_oe_reg) && !$past(start_det) && !$past(stop_det) |-> !scl_pipe_reg[2];
	endproperty
	a_sda_low_clock: assert property (p_sda_low_clock) else $error("data changed while clock high");

	// the line belongs to the master while it acknowledges or while this slave is not addressed
	property p_ack_drive;
		ack_state |-> sda_oe_reg;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not held low");

	property p_master_ack_free;
		state_reg == mag_i2c_pkg::ST_RACK |-> !sda_oe_reg;
	endproperty
	a_master_ack_free: assert property (p_master_ack_free) else $error("line held in master ack");

	property p_idle_quiet;
		state_reg == mag_i2c_pkg::ST_IDLE |-> !sda_oe_reg;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("line driven while not addressed");

	property p_rx_count;
		in_rx |-> bit_cnt_reg <= mag_i2c_pkg::BITS_PER_BYTE;
	endproperty
	a_rx_count: assert property (p_rx_count) else $error("byte longer than eight bits");

	property p_first_bit;
		tx_load |=> sda_oe_reg == !tx_reg[7];
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("read byte did not start with its top bit");

	property p_write_lands;
		wr_a |=> (config_a_reg & mag_i2c_pkg::MASK_CONFIG_A)
			== ($past(shift_reg) & mag_i2c_pkg::MASK_CONFIG_A);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write data not stored");

	// a fresh snapshot each time a burst passes X high keeps the axes of one sample together
	property p_snapshot;
		tx_load && ptr_reg == mag_i2c_pkg::OFS_FIELD_X_MSB |=> snap_reg == $past(sample);
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("field snapshot not taken with X high");

	c_write: cover property (wr_a);
	c_read_burst: cover property (rd_sent && master_ack_reg);
	c_status_wrap: cover property (ptr_adv && ptr_reg == mag_i2c_pkg::OFS_SENSOR_STATE);
	c_restart: cover property (start_det && state_reg != mag_i2c_pkg::ST_IDLE);
	c_foreign: cover property (addr_nack);

endmodule // mag_i2c_slave

/* bench/mag_bus_master.sv */
// two-wire bus master model: makes scl and pulls sda low against a pull-up.
// assumes the slave's sda_oe pulls the line low; all timing is counted in clk cycles.
`timescale 1ns/100ps
module mag_bus_master (
	input wire logic clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic pull_low;
	// released line floats high through the pull-up
	assign sda = !(sda_oe || pull_low);
	initial
	begin
		scl = 1'h1;
		pull_low = 1'h0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// sampled mid-high so the slave's late answer after the fall has settled
	task automatic bit_io(input logic b, output logic s);
		wait_clk(2);
		pull_low = !b;
		wait_clk(2);
		scl = 1'h1;
		wait_clk(2);
		s = sda;
		wait_clk(2);
		scl = 1'h0;
	endtask
	// msb first, then a ninth clock; mack high releases sda for the slave
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], s);
			r[i] = s;
		end
		bit_io(mack, ack);
	endtask
	task automatic start();
		pull_low = 1'h0;
		wait_clk(4);
		scl = 1'h1;
		wait_clk(2);
		pull_low = 1'h1;
		wait_clk(2);
		scl = 1'h0;
	endtask
	task automatic stop();
		wait_clk(2);
		pull_low = 1'h1;
		wait_clk(2);
		scl = 1'h1;
		wait_clk(2);
		pull_low = 1'h0;
		wait_clk(4);
	endtask
endmodule // mag_bus_master

/* bench/test_mag_i2c_slave.sv */
// self-checking bench of the magnetic two-wire slave: registers, pointer rules, address filter.
// assumes mag_bus_master drives the bus; sample and sensor state stay steady.
`timescale 1ns/100ps
module test_mag_i2c_slave;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic scl;
	logic sda;
	logic sda_out;
	logic sda_oe;
	mag_i2c_pkg::field_sample_s sample = '{x: 16'hF123, y: 16'h0456, z: 16'h8001};
	logic [7:0] state_in = 8'h03;
	logic [7:0] config_a;
	logic [7:0] config_b;
	logic [7:0] operating_mode;
	logic [7:0] got [0:15];
	logic [7:0] exp [0:15];
	logic [7:0] rd;
	logic ack;
	int error_cnt = 0;
	int tests_run = 0;

	always #25 clk = !clk;

	mag_i2c_slave dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.sample(sample), .sensor_state_in(state_in), .config_a(config_a), .config_b(config_b),
		.operating_mode(operating_mode));
	mag_bus_master m (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic point(input logic [7:0] p);
		m.start();
		m.xfer(8'h3C, 1'h1, rd, ack);
		chk("addr ack", 8'h00, {7'h0, ack});
		m.xfer(p, 1'h1, rd, ack);
		chk("ptr ack", 8'h00, {7'h0, ack});
	endtask
	task automatic write_at(input logic [7:0] p, input logic [7:0] d [$]);
		point(p);
		foreach (d[i])
		begin
			m.xfer(d[i], 1'h1, rd, ack);
			chk("data ack", 8'h00, {7'h0, ack});
		end
		m.stop();
	endtask
	// last byte gets no master acknowledge so the slave lets go before the stop
	task automatic read_at(input logic [7:0] p, input int n);
		point(p);
		m.start();
		m.xfer(8'h3D, 1'h1, rd, ack);
		chk("read ack", 8'h00, {7'h0, ack});
		for (int i = 0; i < n; i++)
		begin
			m.xfer(8'hFF, i == n - 1, rd, ack);
			got[i] = rd;
		end
		m.stop();
	endtask
	task automatic cmp_burst(input string what, input int n);
		for (int i = 0; i < n; i++)
			chk(what, exp[i], got[i]);
	endtask
	task automatic chk_cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] o);
		chk("config_a", a, config_a);
		chk("config_b", b, config_b);
		chk("operating_mode", o, operating_mode);
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		#1 rst_n = 1'h1;
		m.wait_clk(3);
		chk_cfg(8'h10, 8'h20, 8'h03);
		chk("sda_oe", 8'h00, {7'h0, sda_oe});
		chk("sda_out", 8'h00, {7'h0, sda_out});
		$display("test reset done");
		// fourth byte lands on read-only x msb and must not disturb anything
		write_at(8'h00, '{8'h5A, 8'hA5, 8'h01, 8'h77});
		chk_cfg(8'h5A, 8'hA5, 8'h01);
		$display("test write burst done");
		read_at(8'h03, 9);
		for (int i = 0; i < 6; i++)
			exp[i] = sample[47 - 8 * i -: 8];
		exp[6] = state_in;
		exp[7] = exp[0];
		exp[8] = exp[1];
		cmp_burst("field burst", 9);
		$display("test field burst done");
		read_at(8'h0A, 4);
		exp[0] = 8'hA5;
		exp[1] = 8'h5A;
		exp[2] = 8'hC3;
		exp[3] = 8'h5A;
		cmp_burst("ident burst", 4);
		// no pointer byte: the read carries on from location 01
		m.start();
		m.xfer(8'h3D, 1'h1, rd, ack);
		chk("read ack", 8'h00, {7'h0, ack});
		m.xfer(8'hFF, 1'h1, rd, ack);
		m.stop();
		chk("current pointer", 8'hA5, rd);
		$display("test ident done");
		read_at(8'h0D, 2);
		exp[0] = 8'h00;
		exp[1] = 8'h5A;
		cmp_burst("undefined read", 2);
		write_at(8'h0D, '{8'hEE});
		chk_cfg(8'h5A, 8'hA5, 8'h01);
		$display("test undefined done");
		m.start();
		m.xfer(8'h3A, 1'h1, rd, ack);
		chk("foreign ack", 8'h01, {7'h0, ack});
		m.xfer(8'h00, 1'h1, rd, ack);
		chk("foreign data ack", 8'h01, {7'h0, ack});
		m.stop();
		chk_cfg(8'h5A, 8'hA5, 8'h01);
		$display("test foreign address done");
		rst_n = 1'h0;
		m.wait_clk(2);
		rst_n = 1'h1;
		m.wait_clk(3);
		chk_cfg(8'h10, 8'h20, 8'h03);
		$display("test second reset done");
		stop_test();
	end
	// the whole sequence needs about 140 us of bus time; the 1 ms limit is about seven times that, so reaching it means a hang
	initial
	begin
		#1000000;
		error_cnt++;
		stop_test();
	end
endmodule // test_mag_i2c_slave
